// *** duqc_pkg.sv ***
// Package for the dual up/down quadrature counter: modes, widths, timing.
// Assumes a single 100 MHz core clock; no register bus, plain ports only.
package duqc_pkg;

  localparam int CLK_HZ = 100_000_000;
  localparam int CNT_W = 32;
  localparam int SRC_W = 32;
  localparam int FILT_MIN_HZ = 10;
  localparam int FILT_MAX_HZ = 90;
  // Filter span is half the chosen period, in core clock cycles
  localparam int FILT_CNT_W = 24;

  typedef enum logic [1:0] {
    DUQC_SUM = 2'h0,
    DUQC_DIFF = 2'h1,
    DUQC_QUAD1 = 2'h2,
    DUQC_QUAD4 = 2'h3
  } duqc_mode_t;

  typedef enum logic [1:0] {
    DUQC_CLR_NONE = 2'h0,
    DUQC_CLR_CHAN = 2'h1,
    DUQC_CLR_EXT = 2'h2,
    DUQC_CLR_BOTH = 2'h3
  } duqc_clr_t;

  typedef enum logic [1:0] {
    DUQC_PROG_OFF = 2'h0,
    DUQC_PROG_DIR = 2'h1,
    DUQC_PROG_INH = 2'h2
  } duqc_prog_t;

  // Usage of the channel
  typedef enum logic [1:0] {
    DUQC_USE_COUNT = 2'h0,
    DUQC_USE_FLOW = 2'h1,
    DUQC_USE_BIN = 2'h2
  } duqc_use_t;

  // Per-channel configuration
  typedef struct packed {
    duqc_use_t usage;
    duqc_mode_t mode;
    duqc_clr_t clr_mode;
    duqc_prog_t prog_mode;
    logic [6:0] filt_hz; // 0 disables the filter
    logic signed [CNT_W-1:0] low_limit;
    logic signed [CNT_W-1:0] high_limit;
  } duqc_cfg_t;

  // Per-channel status
  typedef struct packed {
    logic signed [CNT_W-1:0] count;
    logic under_limit_flag;
    logic upper_limit_flag;
    logic bin_a;
    logic bin_b;
    logic flow_pulse;
  } duqc_stat_t;

endpackage

// *** duqc_filter.sv ***
// Debounce filter for one synchronised input line.
// Assumes the input is already in the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module duqc_filter #(
  parameter int CLK_HZ = duqc_pkg::CLK_HZ
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic din,
  input wire logic [6:0] filt_hz,
  output logic dout
);
  localparam int CW = duqc_pkg::FILT_CNT_W;
  // Half period at the slowest rate must fit the counter, and the
  // fastest rate still needs at least one cycle of span
  if (CLK_HZ / (2 * duqc_pkg::FILT_MIN_HZ) >= (1 << CW) ||
      CLK_HZ < 2 * duqc_pkg::FILT_MAX_HZ) begin : g_bad_clk
    $error("duqc_filter: clock rate does not suit the filter counter");
  end

  logic [CW-1:0] span;
  logic [CW-1:0] run_q;
  logic filt_on;

  // Half period of the chosen rate; out-of-range rates are clamped
  always_comb begin
    int hz;
    hz = int'(filt_hz);
    if (hz < duqc_pkg::FILT_MIN_HZ) hz = duqc_pkg::FILT_MIN_HZ;
    if (hz > duqc_pkg::FILT_MAX_HZ) hz = duqc_pkg::FILT_MAX_HZ;
    span = CW'(CLK_HZ / (2 * hz));
  end
  assign filt_on = (filt_hz != 7'h00);

  // A level must outlast half the period before it passes, so bounce
  // shorter than that never reaches the edge logic
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= '0;
      dout <= 1'b0;
    end else if (!filt_on) begin
      run_q <= '0;
      dout <= din;
    end else if (din == dout) begin
      run_q <= '0;
    end else if (run_q >= span) begin
      run_q <= '0;
      dout <= din;
    end else begin
      run_q <= run_q + 1'b1;
    end
  end
endmodule // duqc_filter
`default_nettype wire

// *** duqc_chan.sv ***
// One counter channel: sync, filter, edge detect, mode decode, count.
// Assumes pins arrive asynchronously and config comes from core logic.
`timescale 1ns/1ps
`default_nettype none
module duqc_chan #(
  parameter int CLK_HZ = duqc_pkg::CLK_HZ
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pin_a,
  input wire logic pin_b,
  input wire logic pin_clr,
  input wire logic signed [duqc_pkg::SRC_W-1:0] prog_value,
  input wire logic signed [duqc_pkg::SRC_W-1:0] clr_src_value,
  input wire logic manual_clr,
  input wire duqc_pkg::duqc_cfg_t cfg,
  output duqc_pkg::duqc_stat_t stat
);
  localparam int CW = duqc_pkg::CNT_W;

  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic fa, fb;
  logic a_prev_q, b_prev_q;
  logic rise_a, rise_b;
  logic prog_act, dir_swap, inhibit;
  logic clr_hit;
  logic signed [2:0] step;
  logic signed [CW-1:0] cnt_q;

  // Two-stage synchroniser for a, b and external clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
    end else begin
      s1_q <= {pin_clr, pin_b, pin_a};
      s2_q <= s1_q;
    end
  end

  duqc_filter #(.CLK_HZ(CLK_HZ)) u_filt_a (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .din(s2_q[0]),
    .filt_hz(cfg.filt_hz),
    .dout(fa)
  );
  duqc_filter #(.CLK_HZ(CLK_HZ)) u_filt_b (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .din(s2_q[1]),
    .filt_hz(cfg.filt_hz),
    .dout(fb)
  );

  // Previous filtered samples for edge detection
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_prev_q <= 1'b0;
      b_prev_q <= 1'b0;
    end else begin
      a_prev_q <= fa;
      b_prev_q <= fb;
    end
  end
  assign rise_a = fa & ~a_prev_q;
  assign rise_b = fb & ~b_prev_q;

  // Control input decode
  assign prog_act = (prog_value > 0);
  assign dir_swap = prog_act && (cfg.prog_mode == duqc_pkg::DUQC_PROG_DIR);
  assign inhibit = prog_act && (cfg.prog_mode == duqc_pkg::DUQC_PROG_INH);

  // Clear sources by mode
  always_comb begin
    clr_hit = manual_clr;
    unique case (cfg.clr_mode)
      duqc_pkg::DUQC_CLR_NONE: ;
      duqc_pkg::DUQC_CLR_CHAN: clr_hit = clr_hit | (clr_src_value > 0);
      duqc_pkg::DUQC_CLR_EXT: clr_hit = clr_hit | s2_q[2];
      duqc_pkg::DUQC_CLR_BOTH:
        clr_hit = clr_hit | s2_q[2] | (clr_src_value > 0);
    endcase
  end

  // Net step per cycle; both edges together give up to two in sum mode
  always_comb begin
    logic signed [1:0] ua, ub;
    ua = 2'sd0;
    ub = 2'sd0;
    unique case (cfg.mode)
      duqc_pkg::DUQC_SUM: begin
        ua = rise_a ? 2'sd1 : 2'sd0;
        ub = rise_b ? 2'sd1 : 2'sd0;
      end
      duqc_pkg::DUQC_DIFF: begin
        ua = rise_a ? (dir_swap ? -2'sd1 : 2'sd1) : 2'sd0;
        ub = rise_b ? (dir_swap ? 2'sd1 : -2'sd1) : 2'sd0;
      end
      duqc_pkg::DUQC_QUAD1: begin
        ua = rise_a ? (((fb) ^ dir_swap) ? 2'sd1 : -2'sd1) : 2'sd0;
      end
      duqc_pkg::DUQC_QUAD4: begin
        ua = rise_a ? (((fb) ^ dir_swap) ? 2'sd1 : -2'sd1) : 2'sd0;
        ub = rise_b ? (((fa) ^ dir_swap) ? 2'sd1 : -2'sd1) : 2'sd0;
      end
    endcase
    // Three bits, as a and b together reach plus two in sum mode
    step = 3'(ua) + 3'(ub);
  end

  // Count register: clear wins, inhibit or binary usage holds, otherwise wrap-around add
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (clr_hit) begin
      cnt_q <= '0;
    end else if (!inhibit && cfg.usage != duqc_pkg::DUQC_USE_BIN) begin
      cnt_q <= cnt_q + CW'(step);
    end
  end

  // Status flops: limits, binary levels and flow pulse
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat <= '0;
    end else begin
      stat.count <= cnt_q;
      stat.under_limit_flag <= (cnt_q < cfg.low_limit);
      stat.upper_limit_flag <= (cnt_q > cfg.high_limit);
      stat.bin_a <= fa;
      stat.bin_b <= fb;
      stat.flow_pulse <= (cfg.usage == duqc_pkg::DUQC_USE_FLOW) & rise_a;
    end
  end
endmodule // duqc_chan
`default_nettype wire

// *** duqc_top.sv ***
// Top of the dual counter: reset release and two independent channels.
// Assumes async pins and config/status straight on ports, one clock.
`timescale 1ns/1ps
`default_nettype none
module duqc_top #(
  parameter int CLK_HZ = duqc_pkg::CLK_HZ
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [1:0] pin_a,
  input wire logic [1:0] pin_b,
  input wire logic [1:0] pin_clr,
  input wire logic [1:0] manual_clr,
  input wire logic signed [duqc_pkg::SRC_W-1:0] prog_value0,
  input wire logic signed [duqc_pkg::SRC_W-1:0] prog_value1,
  input wire logic signed [duqc_pkg::SRC_W-1:0] clr_src_value0,
  input wire logic signed [duqc_pkg::SRC_W-1:0] clr_src_value1,
  input wire duqc_pkg::duqc_cfg_t cfg0,
  input wire duqc_pkg::duqc_cfg_t cfg1,
  output duqc_pkg::duqc_stat_t stat0,
  output duqc_pkg::duqc_stat_t stat1
);
  logic rst_s1_q, rst_n_q;

  // Async assert, two-flop synchronous release
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // Two fully independent channels
  duqc_chan #(.CLK_HZ(CLK_HZ)) u_ch0 (
    .core_clk(core_clk),
    .rst_n(rst_n_q),
    .pin_a(pin_a[0]),
    .pin_b(pin_b[0]),
    .pin_clr(pin_clr[0]),
    .prog_value(prog_value0),
    .clr_src_value(clr_src_value0),
    .manual_clr(manual_clr[0]),
    .cfg(cfg0),
    .stat(stat0)
  );
  duqc_chan #(.CLK_HZ(CLK_HZ)) u_ch1 (
    .core_clk(core_clk),
    .rst_n(rst_n_q),
    .pin_a(pin_a[1]),
    .pin_b(pin_b[1]),
    .pin_clr(pin_clr[1]),
    .prog_value(prog_value1),
    .clr_src_value(clr_src_value1),
    .manual_clr(manual_clr[1]),
    .cfg(cfg1),
    .stat(stat1)
  );
endmodule // duqc_top
`default_nettype wire

// *** duqc_src.sv ***
// Pulse source model for the a and b pins of one channel.
// Assumes put is called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module duqc_src (
  input wire logic clk,
  output logic a,
  output logic b
);
  // Optoisolated sources always drive a level
  initial {a, b} = 2'h0;
  // Hold each level n cycles, so slow or prompt sources alike
  task automatic put(input logic [1:0] v, input int n);
    {a, b} = v;
    repeat (n) @(posedge clk);
    #1;
  endtask
endmodule // duqc_src
`default_nettype wire

// *** duqc_chk.sv ***
// Checker on channel 0 ports of the dual counter top.
// Assumes filter off while clears are timed, quiet pins at mode swaps.
`timescale 1ns/1ps
`default_nettype none
module duqc_chk (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [1:0] pin_clr,
  input wire logic [1:0] manual_clr,
  input wire logic signed [duqc_pkg::SRC_W-1:0] prog_value0,
  input wire logic signed [duqc_pkg::SRC_W-1:0] clr_src_value0,
  input wire duqc_pkg::duqc_cfg_t cfg0,
  input wire duqc_pkg::duqc_stat_t stat0
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic [3:0] clr_q, inh_q;
  wire logic clr_now = (cfg0.clr_mode[0] && clr_src_value0 > 0) ||
    (cfg0.clr_mode[1] && pin_clr[0] && cfg0.filt_hz == 7'h0);
  wire logic inh_now = cfg0.prog_mode == duqc_pkg::DUQC_PROG_INH &&
    prog_value0 > 0;
  // Saturating spans of clear and inhibit, long waits beat repetition
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      clr_q <= 4'h0;
      inh_q <= 4'h0;
    end else begin
      clr_q <= clr_now ? clr_q + {3'h0, clr_q != 4'hf} : 4'h0;
      inh_q <= inh_now ? inh_q + {3'h0, inh_q != 4'hf} : 4'h0;
    end
  end
  property p_mclr;
    manual_clr[0] [*6] |-> stat0.count == 0;
  endproperty
  a_mclr: assert property (p_mclr) else $error("manual clear");
  property p_clr;
    clr_q >= 4'h8 |-> stat0.count == 0;
  endproperty
  a_clr: assert property (p_clr) else $error("extra clear");
  property p_lo;
    $past(resetn, 5) |-> stat0.under_limit_flag ==
      (stat0.count < $past(cfg0.low_limit));
  endproperty
  a_lo: assert property (p_lo) else $error("under flag");
  property p_hi;
    $past(resetn, 5) |-> stat0.upper_limit_flag ==
      (stat0.count > $past(cfg0.high_limit));
  endproperty
  a_hi: assert property (p_hi) else $error("upper flag");
  property p_sum;
    cfg0.mode == duqc_pkg::DUQC_SUM &&
      $past(cfg0.mode, 6) == duqc_pkg::DUQC_SUM |->
      (stat0.count - $past(stat0.count)) inside {0, 1, 2} || stat0.count == 0;
  endproperty
  a_sum: assert property (p_sum) else $error("sum not additive");
  property p_bin;
    cfg0.usage == duqc_pkg::DUQC_USE_BIN &&
      $past(cfg0.usage, 6) == duqc_pkg::DUQC_USE_BIN |->
      $stable(stat0.count) || stat0.count == 0;
  endproperty
  a_bin: assert property (p_bin) else $error("binary use counted");
  property p_inh;
    inh_q >= 4'h8 |-> $stable(stat0.count) || stat0.count == 0;
  endproperty
  a_inh: assert property (p_inh) else $error("inhibit counted");
  property p_pulse;
    stat0.flow_pulse |=> !stat0.flow_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("flow pulse long");
  c_flow: cover property (stat0.flow_pulse);
  c_inh: cover property (inh_q == 4'h8);
  c_clr: cover property (clr_q == 4'h8);
endmodule // duqc_chk
bind duqc_top duqc_chk duqc_chk_i (.core_clk, .resetn, .pin_clr,
  .manual_clr, .prog_value0, .clr_src_value0, .cfg0, .stat0);
`default_nettype wire

// *** dual_updown_quadrature_counter_test.sv ***
// Bench for the dual counter: mode table, clears, limits, filter.
// Assumes the source model on channel 0 pins and a bound checker.
`timescale 1ns/1ps
`default_nettype none
module dual_updown_quadrature_counter_test;
  logic core_clk = 1'b0, resetn = 1'b0, sa, sb, a1 = 1'b0;
  logic [1:0] pin_clr = 2'h0, manual_clr = 2'h0;
  logic signed [31:0] pv = 32'h0, cs = 32'h0;
  duqc_pkg::duqc_cfg_t c0, c1;
  duqc_pkg::duqc_stat_t s0, s1;
  int errors = 0, checked = 0, flows = 0;
  duqc_src duqc_src_i (.clk(core_clk), .a(sa), .b(sb));
  // Short clock rate keeps the filter spans brief
  duqc_top #(.CLK_HZ(1000)) duqc_top_i (.core_clk(core_clk),
    .resetn(resetn), .pin_a({a1, sa}), .pin_b({1'b0, sb}),
    .pin_clr(pin_clr), .manual_clr(manual_clr), .prog_value0(pv),
    .prog_value1(32'h0), .clr_src_value0(cs), .clr_src_value1(32'h0),
    .cfg0(c0), .cfg1(c1), .stat0(s0), .stat1(s1));
  initial forever #5 core_clk = ~core_clk;
  // Flow pulses tallied on their own
  always @(posedge core_clk) if (s0.flow_pulse === 1'b1) flows++;
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic signed [31:0] got, input int e);
    checked++;
    if (got !== e) begin
      errors++;
      $display("[ERR] %0t got %0d exp %0d", $time, got, e);
    end
  endtask
  // Modes 0 sum, 1 diff, 2 quad, 3 quad4; prog 1 dir, 2 inhibit
  task automatic run(input int m, p, v, input logic [15:0] sq, input int e);
    c0.mode = duqc_pkg::duqc_mode_t'(m);
    c0.prog_mode = duqc_pkg::duqc_prog_t'(p);
    pv = v;
    manual_clr[0] = 1'b1;
    tick(8);
    manual_clr[0] = 1'b0;
    chk(s0.count, 0);
    for (int i = 0; i < 8; i++) duqc_src_i.put(sq[2*i+:2], 4);
    tick(10);
    chk(s0.count, e);
    chk(s0.under_limit_flag, e < 2);
    chk(s0.upper_limit_flag, e > 3);
    $display("run %0h done", sq);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    c0 = '0;
    c0.low_limit = 32'h2;
    c0.high_limit = 32'h3;
    c1 = c0;
    tick(2);
    resetn = 1'b1;
    tick(3);
    run(0, 0, 0, 16'h0c81, 4);
    run(0, 1, 1, 16'h0c81, 4);
    run(1, 0, 0, 16'h0422, 1);
    run(1, 1, 1, 16'h0422, -1);
    run(1, 1, 0, 16'h0422, 1);
    run(1, 0, 7, 16'h0422, 1);
    run(2, 0, 0, 16'h21dd, 1);
    run(2, 1, 1, 16'h21dd, -1);
    run(3, 0, 0, 16'h0dee, 2);
    run(3, 1, 1, 16'h0dee, -2);
    run(0, 2, 1, 16'h0c81, 0);
    run(0, 2, 0, 16'h0c81, 4);
    // Every clear mode against both extra sources
    for (int k = 0; k < 8; k++) begin
      c0.clr_mode = duqc_pkg::duqc_clr_t'(k / 2);
      run(0, 0, 0, 16'h0c81, 4);
      pin_clr[0] = k[0];
      cs = {31'h0, !k[0]};
      tick(10);
      chk(s0.count, c0.clr_mode[k % 2] ? 0 : 4);
      pin_clr[0] = 1'b0;
      cs = 32'h0;
    end
    c0.usage = duqc_pkg::DUQC_USE_BIN;
    run(0, 0, 0, 16'h0c81, 0);
    duqc_src_i.put(2'h2, 8);
    chk(s0.bin_a, 1);
    chk(s0.bin_b, 0);
    c0.usage = duqc_pkg::DUQC_USE_FLOW;
    // Pin a is still high, so drop it first to get four clean rises
    for (int i = 0; i < 8; i++) duqc_src_i.put(2'h2 * (i % 2 == 1), 4);
    tick(10);
    chk(flows, 4);
    c0.usage = duqc_pkg::DUQC_USE_COUNT;
    c0.filt_hz = 7'h0a;
    run(0, 0, 0, 16'h0, 0);
    duqc_src_i.put(2'h2, 40);
    duqc_src_i.put(2'h0, 60);
    duqc_src_i.put(2'h2, 60);
    duqc_src_i.put(2'h0, 60);
    chk(s0.count, 1);
    chk(s1.count, 0);
    a1 = 1'b1;
    tick(4);
    a1 = 1'b0;
    tick(10);
    chk(s1.count, 1);
    $display("filter and channel 1 done");
    results();
  end
  // Whole run is some 1500 cycles
  initial begin
    #100000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end
endmodule // dual_updown_quadrature_counter_test
`default_nettype wire
